// ### hdl/alc_link_ctrl.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module alc_link_ctrl (
  // Clock, enable and reset.
  input wire logic core_clk,
  input wire logic ce,
  input wire logic reset_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link pins.
  input wire logic bitClkIn,
  input wire logic serialInPin,
  input wire logic secondarySerialIn,
  output logic codecResetNOut,
  output logic frameSyncOut,
  output logic serialOutPin
);

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------

  alc_sync_if pinSync ();
  assign pinSync.asyncIn = {bitClkIn, serialInPin, secondarySerialIn};

  alc_sync2 pinSyncU (
    .core_clk(core_clk),
    .ce(ce),
    .reset_n(reset_n),
    .port(pinSync.sync)
  );

  // Clean pin levels.
  logic bitClkS;
  logic serialInS;
  logic serialIn2S;
  assign bitClkS = pinSync.syncOut[2];
  assign serialInS = pinSync.syncOut[1];
  assign serialIn2S = pinSync.syncOut[0];

  // ---------------------------------------------------------------
  // Wishbone slave.
  // ---------------------------------------------------------------

  logic ack_r, ack_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic [31:0] regWord;
  logic [31:0] wrWord;
  logic [11:0] wordAdr;
  logic wbReq;
  logic wrDo;
  logic rdDo;

  // Register state, declared here because the read mux needs it.
  logic [6:0] ctrl_r, ctrl_nxt;
  logic [9:0] slv_r, slv_nxt;
  logic [6:0] cad_r, cad_nxt;
  logic [15:0] cda_r, cda_nxt;
  logic [9:0] isv_r, isv_nxt;
  logic [6:0] sad_r, sad_nxt;
  logic [15:0] sda_r, sda_nxt;
  logic codec_ready_flag_r, codec_ready_flag_nxt;
  logic status_capture_valid_r, status_capture_valid_nxt;
  logic wake_r, wake_nxt;

  // Merges written bytes over the current word under the byte selects.
  function automatic logic [31:0] wrMerge(input logic [31:0] old,
    input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  assign wordAdr = {wb_adr_i[11:2], 2'b00};
  assign wbReq = wb_cyc_i & wb_stb_i;
  // Writes and read side effects land on the edge that sees ack.
  assign wrDo = ce & wbReq & wb_we_i & ack_r;
  assign rdDo = ce & wbReq & ~wb_we_i & ack_r;
  assign wrWord = wrMerge(regWord, wb_dat_i, wb_sel_i);

  // Read mux; unmapped addresses read as zero and still answer.
  always_comb
  begin
    case (wordAdr)
      alc_pkg::ALC_OFF_CTRL: regWord = {25'h0, ctrl_r};
      alc_pkg::ALC_OFF_STATUS: regWord = {29'h0, wake_r, status_capture_valid_r, codec_ready_flag_r};
      alc_pkg::ALC_OFF_SLV: regWord = {22'h0, slv_r};
      alc_pkg::ALC_OFF_CAD: regWord = {25'h0, cad_r};
      alc_pkg::ALC_OFF_CDA: regWord = {16'h0, cda_r};
      alc_pkg::ALC_OFF_ISV: regWord = {22'h0, isv_r};
      alc_pkg::ALC_OFF_SAD: regWord = {25'h0, sad_r};
      alc_pkg::ALC_OFF_SDA: regWord = {16'h0, sda_r};
      default: regWord = 32'h0;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after.
  always_comb
  begin
    ack_nxt = wbReq & ~ack_r;
    rdData_nxt = ack_nxt ? regWord : rdData_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ack_r <= 1'b0;
      rdData_r <= 32'h0;
    end
    else if (ce)
    begin
      ack_r <= ack_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  // ---------------------------------------------------------------
  // Link framing, command send and status capture.
  // ---------------------------------------------------------------

  alc_pkg::alc_link_t link_r, link_nxt;
  logic bclkPrev_r;
  logic [7:0] bitIdx_r, bitIdx_nxt;
  logic [7:0] idxInc;
  logic cmdFrame_r, cmdFrame_nxt;
  logic syncGen_r, syncGen_nxt;
  logic syncOut_r, syncOut_nxt;
  logic serOut_r, serOut_nxt;
  logic [19:0] inShift_r, inShift_nxt;
  logic [19:0] newShift;
  logic [6:0] addrTmp_r, addrTmp_nxt;
  logic slot2Tag_r, slot2Tag_nxt;
  logic ovrPrev_r;
  logic [1:0] dinPrev_r;
  logic bclkRise;
  logic bclkFall;
  logic wakeClr;
  logic outBit;
  logic [4:0] pos;
  logic [15:0] tagWord;
  logic [19:0] slot1Word;
  logic [19:0] slot2Word;
  // Static slot bits in tag order, slot 3 first.
  logic [9:0] slvRev;
  // Received input slot bits in register order, slot 3 in bit 0.
  logic [9:0] isvIn;

  assign bclkRise = bitClkS & ~bclkPrev_r;
  assign bclkFall = ~bitClkS & bclkPrev_r;
  assign idxInc = bitIdx_r + 8'h01;
  assign newShift = {inShift_r[18:0], serialInS};
  // Warm reset ends when the override bit drops.
  assign wakeClr = ovrPrev_r & ~ctrl_r[alc_pkg::ALC_CTRL_SYNC_OVERRIDE];

  // Outgoing tag and command slots; audio slots stay zero.
  assign tagWord = {ctrl_r[alc_pkg::ALC_CTRL_FRAME_VALID_TAG],
    cmdFrame_r, cmdFrame_r,
    slvRev, 3'b000};
  assign slot1Word = {ctrl_r[alc_pkg::ALC_CTRL_CRW], cad_r, 12'h000};
  assign slot2Word = {cda_r, 4'h0};

  // Tag bit 12 carries slot 3 but the registers keep slot 3 in bit 0,
  // so both directions flip the bit order here.
  always_comb
  begin
    for (int i = 0; i < alc_pkg::ALC_SLV_W; i++)
    begin
      slvRev[i] = slv_r[alc_pkg::ALC_SLV_W - 1 - i];
      isvIn[i] = newShift[12 - i];
    end
  end

  // Picks the bit for the next link position, msb first.
  always_comb
  begin
    outBit = 1'b0;
    pos = 5'h00;
    if (idxInc < alc_pkg::ALC_SYNC_LEN)
    begin
      outBit = tagWord[4'hf - idxInc[3:0]];
    end
    else if (idxInc <= alc_pkg::ALC_SLOT1_LAST)
    begin
      pos = 5'(idxInc - alc_pkg::ALC_SLOT1_FIRST);
      outBit = cmdFrame_r & slot1Word[5'h13 - pos];
    end
    else if (idxInc <= alc_pkg::ALC_SLOT2_LAST)
    begin
      pos = 5'(idxInc - alc_pkg::ALC_SLOT2_FIRST);
      outBit = cmdFrame_r & slot2Word[5'h13 - pos];
    end
  end

  // Next values of every register and link flop except bclkPrev_r, ovrPrev_r and dinPrev_r.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    slv_nxt = slv_r;
    cad_nxt = cad_r;
    cda_nxt = cda_r;
    isv_nxt = isv_r;
    sad_nxt = sad_r;
    sda_nxt = sda_r;
    codec_ready_flag_nxt = codec_ready_flag_r;
    status_capture_valid_nxt = status_capture_valid_r;
    wake_nxt = wake_r;
    link_nxt = link_r;
    bitIdx_nxt = bitIdx_r;
    cmdFrame_nxt = cmdFrame_r;
    syncGen_nxt = syncGen_r;
    serOut_nxt = serOut_r;
    inShift_nxt = inShift_r;
    addrTmp_nxt = addrTmp_r;
    slot2Tag_nxt = slot2Tag_r;
    case (link_r)
      alc_pkg::ALC_LINK_DOWN:
      begin
        // Framing starts one bit before position zero.
        bitIdx_nxt = alc_pkg::ALC_BIT_IDLE;
        cmdFrame_nxt = 1'b0;
        syncGen_nxt = 1'b0;
        serOut_nxt = 1'b0;
        if (ctrl_r[alc_pkg::ALC_CTRL_SYNC_GEN_ENABLE])
          link_nxt = alc_pkg::ALC_LINK_UP;
        // A codec lifting either data line asks for wake-up.
        if ((serialInS & ~dinPrev_r[1]) | (serialIn2S & ~dinPrev_r[0]))
          wake_nxt = 1'b1;
      end
      alc_pkg::ALC_LINK_UP:
      begin
        if (!ctrl_r[alc_pkg::ALC_CTRL_SYNC_GEN_ENABLE])
          link_nxt = alc_pkg::ALC_LINK_DOWN;
        // Drive side: advance on each rising bit clock.
        if (bclkRise)
        begin
          bitIdx_nxt = idxInc;
          syncGen_nxt = idxInc < alc_pkg::ALC_SYNC_LEN;
          serOut_nxt = outBit;
          if (idxInc == 8'h00)
            cmdFrame_nxt = ctrl_r[alc_pkg::ALC_CTRL_DCV];
          if (idxInc == alc_pkg::ALC_CMD_DONE && cmdFrame_r)
          begin
            cmdFrame_nxt = 1'b0;
            ctrl_nxt[alc_pkg::ALC_CTRL_DCV] = 1'b0;
            ctrl_nxt[alc_pkg::ALC_CTRL_TC] = 1'b0;
          end
        end
        // Receive side: sample on each falling bit clock.
        if (bclkFall)
        begin
          inShift_nxt = newShift;
          if (bitIdx_r == alc_pkg::ALC_TAG_LAST)
          begin
            codec_ready_flag_nxt = newShift[15];
            slot2Tag_nxt = newShift[13];
            isv_nxt = isvIn;
          end
          if (bitIdx_r == alc_pkg::ALC_SLOT1_LAST)
            addrTmp_nxt = newShift[18:12];
        end
      end
      default: link_nxt = alc_pkg::ALC_LINK_DOWN;
    endcase
    if (wakeClr)
      wake_nxt = 1'b0;
    if (link_r == alc_pkg::ALC_LINK_DOWN && ((serialInS & ~dinPrev_r[1])
      | (serialIn2S & ~dinPrev_r[0])))
      wake_nxt = 1'b1;
    // Reading status data frees the capture pair.
    if (rdDo && wordAdr == alc_pkg::ALC_OFF_SDA)
      status_capture_valid_nxt = 1'b0;
    // Capture needs valid already clear, so a read clear in the same cycle still blocks it.
    if (link_r == alc_pkg::ALC_LINK_UP && bclkFall && slot2Tag_r
      && bitIdx_r == alc_pkg::ALC_SLOT2_LAST && !status_capture_valid_r)
    begin
      status_capture_valid_nxt = 1'b1;
      sad_nxt = addrTmp_r;
      sda_nxt = newShift[19:4];
    end
    // A software write wins over the completion clear.
    if (wrDo)
    begin
      case (wordAdr)
        alc_pkg::ALC_OFF_CTRL: ctrl_nxt = wrWord[6:0];
        alc_pkg::ALC_OFF_SLV: slv_nxt = wrWord[9:0];
        alc_pkg::ALC_OFF_CAD: cad_nxt = wrWord[6:0];
        alc_pkg::ALC_OFF_CDA: cda_nxt = wrWord[15:0];
        default: ;
      endcase
    end
    syncOut_nxt = ctrl_r[alc_pkg::ALC_CTRL_SYNC_OVERRIDE] | syncGen_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ctrl_r <= alc_pkg::ALC_CTRL_RST;
      slv_r <= alc_pkg::ALC_SLV_RST;
      cad_r <= alc_pkg::ALC_IDX_RST;
      cda_r <= alc_pkg::ALC_DATA_RST;
      isv_r <= alc_pkg::ALC_SLV_RST;
      sad_r <= alc_pkg::ALC_IDX_RST;
      sda_r <= alc_pkg::ALC_DATA_RST;
      codec_ready_flag_r <= 1'b0;
      status_capture_valid_r <= 1'b0;
      wake_r <= 1'b0;
      link_r <= alc_pkg::ALC_LINK_DOWN;
      bitIdx_r <= alc_pkg::ALC_BIT_IDLE;
      cmdFrame_r <= 1'b0;
      syncGen_r <= 1'b0;
      syncOut_r <= 1'b0;
      serOut_r <= 1'b0;
      inShift_r <= 20'h0;
      addrTmp_r <= alc_pkg::ALC_IDX_RST;
      slot2Tag_r <= 1'b0;
      bclkPrev_r <= 1'b0;
      ovrPrev_r <= 1'b0;
      dinPrev_r <= 2'b00;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      slv_r <= slv_nxt;
      cad_r <= cad_nxt;
      cda_r <= cda_nxt;
      isv_r <= isv_nxt;
      sad_r <= sad_nxt;
      sda_r <= sda_nxt;
      codec_ready_flag_r <= codec_ready_flag_nxt;
      status_capture_valid_r <= status_capture_valid_nxt;
      wake_r <= wake_nxt;
      link_r <= link_nxt;
      bitIdx_r <= bitIdx_nxt;
      cmdFrame_r <= cmdFrame_nxt;
      syncGen_r <= syncGen_nxt;
      syncOut_r <= syncOut_nxt;
      serOut_r <= serOut_nxt;
      inShift_r <= inShift_nxt;
      addrTmp_r <= addrTmp_nxt;
      slot2Tag_r <= slot2Tag_nxt;
      bclkPrev_r <= bitClkS;
      ovrPrev_r <= ctrl_r[alc_pkg::ALC_CTRL_SYNC_OVERRIDE];
      dinPrev_r <= {serialInS, serialIn2S};
    end
  end

  // Pin drivers, all straight from flops.
  assign codecResetNOut = ctrl_r[alc_pkg::ALC_CTRL_CODEC_RESET_RELEASE];
  assign frameSyncOut = syncOut_r;
  assign serialOutPin = serOut_r;

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Rising bit clock that opens a given link position.
  sequence riseAt(logic [7:0] k);
    ce && link_r == alc_pkg::ALC_LINK_UP && ctrl_r[1] && bclkRise
      && idxInc == k;
  endsequence

  // A read of status data that the bus completes now.
  sequence sdaRead;
    rdDo && wordAdr == alc_pkg::ALC_OFF_SDA;
  endsequence

  codec_reset_a: assert property (
    ce && wrDo && wordAdr == alc_pkg::ALC_OFF_CTRL && wb_sel_i[0]
    |=> codecResetNOut == $past(wb_dat_i[0]))
    else $error("Codec reset pin does not follow control bit.");
  sync_start_a: assert property (
    riseAt(8'h00) ##1 ce |-> syncGen_r ##1 frameSyncOut)
    else $error("Sync not raised at frame start.");
  frame_valid_a: assert property (
    riseAt(8'h00) and (!wrDo) |=> serialOutPin == ctrl_r[2])
    else $error("Frame-valid tag bit wrong.");
  cmd_tag_a: assert property (
    riseAt(8'h01) ##0 cmdFrame_r |=> serialOutPin)
    else $error("Command slot tag not marked valid.");
  cmd_silent_a: assert property (
    riseAt(8'h20) ##0 !cmdFrame_r |=> !serialOutPin)
    else $error("Command data sent without a request.");
  cmd_done_a: assert property (
    riseAt(alc_pkg::ALC_CMD_DONE) ##0 (cmdFrame_r && !wrDo)
    |=> !ctrl_r[3] && !ctrl_r[6] && !cmdFrame_r)
    else $error("Command request not cleared after slot 2.");
  status_hold_a: assert property (
    ce && status_capture_valid_r && !rdDo |=> $stable(sad_r) && $stable(sda_r) && status_capture_valid_r)
    else $error("Captured status changed while valid.");
  status_clear_a: assert property (
    sdaRead ##0 !(bclkFall && bitIdx_r == alc_pkg::ALC_SLOT2_LAST)
    |=> !status_capture_valid_r)
    else $error("Status data read did not clear valid.");
  wake_clear_a: assert property (
    ce && wakeClr && !((serialInS & ~dinPrev_r[1])
    | (serialIn2S & ~dinPrev_r[0])) |=> !wake_r)
    else $error("Warm reset did not clear wake flag.");
  sync_force_a: assert property (
    ce && ctrl_r[5] |=> frameSyncOut)
    else $error("Sync override did not force sync high.");
  slot_valid_a: assert property (
    riseAt(8'h03) and (!wrDo) |=> serialOutPin == slv_r[0])
    else $error("Static slot 3 tag bit wrong.");

endmodule
`default_nettype wire

// ### common/alc_pkg.sv
`default_nettype none
package alc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets.
  // ---------------------------------------------------------------
  localparam logic [11:0] ALC_OFF_CTRL = 12'h460;
  localparam logic [11:0] ALC_OFF_STATUS = 12'h464;
  localparam logic [11:0] ALC_OFF_SLV = 12'h468;
  localparam logic [11:0] ALC_OFF_CAD = 12'h46c;
  localparam logic [11:0] ALC_OFF_CDA = 12'h470;
  localparam logic [11:0] ALC_OFF_ISV = 12'h474;
  localparam logic [11:0] ALC_OFF_SAD = 12'h478;
  localparam logic [11:0] ALC_OFF_SDA = 12'h47c;

  // ---------------------------------------------------------------
  // Field positions and widths.
  // ---------------------------------------------------------------
  localparam int ALC_CTRL_CODEC_RESET_RELEASE = 0;
  localparam int ALC_CTRL_SYNC_GEN_ENABLE = 1;
  localparam int ALC_CTRL_FRAME_VALID_TAG = 2;
  localparam int ALC_CTRL_DCV = 3;
  localparam int ALC_CTRL_CRW = 4;
  localparam int ALC_CTRL_SYNC_OVERRIDE = 5;
  localparam int ALC_CTRL_TC = 6;
  localparam int ALC_CTRL_W = 7;
  localparam int ALC_SLV_W = 10;
  localparam int ALC_IDX_W = 7;
  localparam int ALC_DATA_W = 16;
  localparam int ALC_PIN_W = 3;

  // ---------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------
  localparam logic [6:0] ALC_CTRL_RST = 7'h00;
  localparam logic [9:0] ALC_SLV_RST = 10'h000;
  localparam logic [6:0] ALC_IDX_RST = 7'h00;
  localparam logic [15:0] ALC_DATA_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Frame timing in bit-clock periods.
  // ---------------------------------------------------------------
  localparam logic [7:0] ALC_BIT_IDLE = 8'hff;
  localparam logic [7:0] ALC_SYNC_LEN = 8'h10;
  localparam logic [7:0] ALC_TAG_LAST = 8'h0f;
  localparam logic [7:0] ALC_SLOT1_FIRST = 8'h10;
  localparam logic [7:0] ALC_SLOT1_LAST = 8'h23;
  localparam logic [7:0] ALC_SLOT2_FIRST = 8'h24;
  localparam logic [7:0] ALC_SLOT2_LAST = 8'h37;
  localparam logic [7:0] ALC_CMD_DONE = 8'h38;

  // Link state.
  typedef enum logic {
    ALC_LINK_DOWN = 1'b0,
    ALC_LINK_UP = 1'b1
  } alc_link_t;

endpackage
`default_nettype wire

// ### common/alc_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries raw pin levels into the synchroniser and clean levels back.
interface alc_sync_if;
  logic [alc_pkg::ALC_PIN_W-1:0] asyncIn;
  logic [alc_pkg::ALC_PIN_W-1:0] syncOut;
  modport sync (input asyncIn, output syncOut);
  modport user (output asyncIn, input syncOut);
endinterface
`default_nettype wire

// ### hdl/alc_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module alc_sync2 (
  // Clock, enable and reset.
  input wire logic core_clk,
  input wire logic ce,
  input wire logic reset_n,
  // Pin levels in, clean levels out.
  alc_sync_if.sync port
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser.
  // ---------------------------------------------------------------

  // First stage; only the second stage reads it.
  logic [alc_pkg::ALC_PIN_W-1:0] meta_r;
  // Second stage, the clean level.
  logic [alc_pkg::ALC_PIN_W-1:0] clean_r;

  // Both stages shift together while enabled.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      clean_r <= '0;
    end
    else if (ce)
    begin
      meta_r <= port.asyncIn;
      clean_r <= meta_r;
    end
  end

  assign port.syncOut = clean_r;

endmodule
`default_nettype wire

// ### sim/alc_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Behavioural codec on the far side of the serial link.
// ------------------------------------------------------------
module alc_codec_model (
  // Link pins as the codec sees them.
  input wire logic codecResetNOut,
  input wire logic frameSyncOut,
  input wire logic serialOutPin,
  output logic bitClkIn,
  output logic serialInPin,
  // Bench controls for the returned frames.
  input wire logic readyOn,
  input wire logic statusOn,
  input wire logic [6:0] statusAddr,
  input wire logic [15:0] statusData,
  input wire logic forceHigh,
  // Last complete output frame and the number of frames seen.
  output logic [255:0] lastFrame,
  output int frameCnt
);
  logic [255:0] outFrame; // Output frame being collected, MSB first.
  logic [255:0] inFrame; // Input frame latched at each frame start.
  logic [7:0] outIdx; // Bit position of the collected output bit.
  logic [7:0] inPos; // Bit position being driven back.
  logic syncPrev; // Sync level at the previous bit clock rise.
  logic inBit; // Data bit the codec currently drives.

  initial
  begin
    outFrame = '0;
    inFrame = '0;
    lastFrame = '0;
    frameCnt = 0;
    outIdx = 8'h00;
    inPos = 8'h00;
    syncPrev = 1'b0;
    inBit = 1'b0;
  end

  // The codec owns the bit clock and stops it while held in reset.
  // The small offset keeps its edges clear of the core clock edges.
  initial
  forever
  begin
    if (codecResetNOut !== 1'b1)
    begin
      bitClkIn = 1'b0;
      @(codecResetNOut);
      #7;
    end
    else
      #100 bitClkIn = ~bitClkIn;
  end

  // A rising sync marks bit 0 of a new frame, so the frame just ended is
  // stored whole and a fresh input frame is latched for return.
  always @(posedge bitClkIn)
  begin
    if (frameSyncOut === 1'b1 && syncPrev !== 1'b1)
    begin
      lastFrame = outFrame;
      frameCnt = frameCnt + 1;
      outIdx = 8'h00;
      inPos = 8'h01;
      inFrame = {readyOn, statusOn, statusOn, 13'h0000, 1'b0, statusAddr,
                 12'h000, statusData, 4'h0, 200'h0};
    end
    else
    begin
      outIdx = outIdx + 8'h01;
      inPos = inPos + 8'h01;
    end
    outFrame[8'hff - outIdx] = serialOutPin;
    syncPrev = frameSyncOut;
    inBit = inFrame[8'hff - inPos];
  end

  // A codec in reset drives its data line low unless it signals a wake.
  assign serialInPin = forceHigh | (codecResetNOut === 1'b1 && inBit);
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // Signals.
  // ------------------------------------------------------------
  logic core_clk, reset_n, cyc, stb, we, ack, bitClk, sIn, sIn2;
  logic rstNOut, syncOut, sOut, readyOn, statusOn, forceHigh;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, rd;
  logic [6:0] stAddr;
  logic [15:0] stData;
  logic [255:0] lastFrame;
  int frameCnt, fails, samplesChecked, cycles;

  alc_link_ctrl dut (.core_clk(core_clk), .ce(1'b1), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .bitClkIn(bitClk), .serialInPin(sIn), .secondarySerialIn(sIn2),
    .codecResetNOut(rstNOut), .frameSyncOut(syncOut), .serialOutPin(sOut));

  alc_codec_model codec (.codecResetNOut(rstNOut), .frameSyncOut(syncOut),
    .serialOutPin(sOut), .bitClkIn(bitClk), .serialInPin(sIn),
    .readyOn(readyOn), .statusOn(statusOn), .statusAddr(stAddr),
    .statusData(stData), .forceHigh(forceHigh), .lastFrame(lastFrame),
    .frameCnt(frameCnt));

  // ------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // A hung wait is cut short and counted as a mismatch.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      fails++;
      results();
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] e, g);
    samplesChecked++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic bus cycle; read data lands in rd at the ack edge.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    {cyc, stb, we, adr, datI, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
    // Ack and read data are taken as they stand at each rising edge.
    @(posedge core_clk);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge core_clk);
    end
    if (ack !== 1'b1)
      chk("ack", 32'h1, 32'h0);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Waits for n more frame starts seen by the codec.
  task automatic frames(input int n);
    int t;
    t = frameCnt + n;
    wait (frameCnt >= t);
  endtask

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  // Every register resets to zero; unmapped and read-only writes drop.
  task automatic testResetValues;
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, alc_pkg::ALC_OFF_CTRL + 12'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    bus(1'b1, 12'h480, 32'hffffffff);
    bus(1'b0, 12'h480, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, alc_pkg::ALC_OFF_STATUS, 32'hffffffff);
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("status read only", 32'h0, rd);
    chk("codec reset pin", 32'h0, {31'h0, rstNOut});
    chk("sync pin", 32'h0, {31'h0, syncOut});
  endtask

  // Releasing the codec alone starts no framing.
  task automatic testCodecReset;
    bus(1'b1, alc_pkg::ALC_OFF_CTRL, 32'h1);
    repeat (2000) @(posedge core_clk);
    @(negedge core_clk);
    chk("codec reset pin", 32'h1, {31'h0, rstNOut});
    chk("frames without enable", 32'h0, 32'(frameCnt));
  endtask

  // Tag carries frame valid and static slots; command slots stay silent.
  task automatic testFrameTag;
    bus(1'b1, alc_pkg::ALC_OFF_SLV, 32'h2a5);
    bus(1'b1, alc_pkg::ALC_OFF_CAD, 32'h55);
    bus(1'b1, alc_pkg::ALC_OFF_CDA, 32'ha5a5);
    bus(1'b1, alc_pkg::ALC_OFF_CTRL, 32'h7);
    frames(3);
    // Slot 3 sits in tag bit 12 and comes from register bit 0.
    chk("tag", {16'h0, 3'b100, 10'h295, 3'b000}, 32'(lastFrame[255:240]));
    chk("idle slots", 32'h0, 32'(lastFrame[239:200] != 40'h0));
    bus(1'b0, alc_pkg::ALC_OFF_SLV, 32'h0);
    chk("slot valid readback", 32'h2a5, rd);
  endtask

  // One command frame with its slots, then automatic completion.
  task automatic testCommand(input logic rw, input logic [6:0] a,
                             input logic [15:0] d);
    bus(1'b1, alc_pkg::ALC_OFF_CAD, {25'h0, a});
    bus(1'b1, alc_pkg::ALC_OFF_CDA, {16'h0, d});
    bus(1'b1, alc_pkg::ALC_OFF_CTRL, 32'h7);
    frames(1);
    bus(1'b1, alc_pkg::ALC_OFF_CTRL, {27'h0, rw, 4'hf});
    frames(2);
    chk("cmd tag", 32'h3, 32'(lastFrame[254:253]));
    chk("cmd slot 1", {12'h0, rw, a, 12'h0}, 32'(lastFrame[239:220]));
    chk("cmd slot 2", {12'h0, d, 4'h0}, 32'(lastFrame[219:200]));
    bus(1'b0, alc_pkg::ALC_OFF_CTRL, 32'h0);
    chk("cmd done", {27'h0, rw, 4'h7}, rd);
    frames(1);
    chk("cmd tag after", 32'h0, 32'(lastFrame[254:253]));
  endtask

  // Status capture, hold while valid, and clear on data read.
  task automatic testStatus;
    {readyOn, statusOn, stAddr, stData} <= {2'b11, 7'h26, 16'h1234};
    frames(3);
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("ready and valid", 32'h3, rd);
    {stAddr, stData} <= {7'h7f, 16'hfedc};
    frames(2);
    statusOn <= 1'b0;
    frames(2);
    bus(1'b0, alc_pkg::ALC_OFF_SAD, 32'h0);
    chk("held address", 32'h26, rd);
    bus(1'b0, alc_pkg::ALC_OFF_SDA, 32'h0);
    chk("held data", 32'h1234, rd);
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("valid cleared", 32'h1, rd);
    statusOn <= 1'b1;
    frames(2);
    statusOn <= 1'b0;
    readyOn <= 1'b0;
    frames(3);
    bus(1'b0, alc_pkg::ALC_OFF_SAD, 32'h0);
    chk("next address", 32'h7f, rd);
    bus(1'b0, alc_pkg::ALC_OFF_SDA, 32'h0);
    chk("next data", 32'hfedc, rd);
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("not ready", 32'h0, rd);
  endtask

  // Wake from either data input while down, cleared by warm reset.
  task automatic testWake;
    bus(1'b1, alc_pkg::ALC_OFF_CTRL, 32'h0);
    repeat (20) @(posedge core_clk);
    sIn2 <= 1'b1;
    repeat (10) @(posedge core_clk);
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("wake secondary", 32'h4, rd);
    bus(1'b1, alc_pkg::ALC_OFF_CTRL, 32'h20);
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    chk("warm reset sync", 32'h1, {31'h0, syncOut});
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("wake held", 32'h4, rd);
    bus(1'b1, alc_pkg::ALC_OFF_CTRL, 32'h0);
    repeat (10) @(posedge core_clk);
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("wake cleared", 32'h0, rd);
    chk("sync released", 32'h0, {31'h0, syncOut});
    sIn2 <= 1'b0;
    repeat (10) @(posedge core_clk);
    forceHigh <= 1'b1;
    repeat (10) @(posedge core_clk);
    bus(1'b0, alc_pkg::ALC_OFF_STATUS, 32'h0);
    chk("wake primary", 32'h4, rd);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial
  begin
    {reset_n, cyc, stb, we, adr, sel, datI, sIn2} = '0;
    {readyOn, statusOn, forceHigh, stAddr, stData} = '0;
    {fails, samplesChecked, cycles} = '0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    testResetValues();
    testCodecReset();
    testFrameTag();
    testCommand(1'b0, 7'h2c, 16'hbeef);
    testCommand(1'b1, 7'h7f, 16'h0000);
    testStatus();
    testWake();
    results();
  end
endmodule
`default_nettype wire
